// file: hw/fcc_pkg.sv
package fcc_pkg;

    // register offsets
    localparam logic [7:0] REG_CFG1 = 8'h00;
    localparam logic [7:0] REG_CFG2 = 8'h01;
    localparam logic [7:0] REG_STAT1 = 8'h02;

    // fan_control_configuration fields
    localparam int CFG1_AUTO = 7;
    localparam int CFG1_SRC_HI = 6;
    localparam int CFG1_SRC_LO = 5;
    localparam int CFG1_FFEN = 4;
    localparam int CFG1_INV = 3;
    localparam int CFG1_ANA = 2;
    localparam int CFG1_INTEN = 1;
    localparam int CFG1_MON = 0;

    // interrupt_and_output_configuration fields
    localparam int CFG2_SRST = 7;
    localparam int CFG2_REM = 5;
    localparam int CFG2_LOC = 4;
    localparam int CFG2_INMASK = 3;
    localparam int CFG2_TACH = 2;
    localparam int CFG2_TO = 1;
    localparam int CFG2_PWM = 0;

    // alarm_status_first fields
    localparam int STAT1_ALARM = 0;

    // variants
    localparam logic [1:0] VAR_LOW_DUTY = 2'h0;
    localparam logic [1:0] VAR_FULL_DUTY = 2'h1;
    localparam logic [1:0] VAR_AUTO = 2'h2;

    // power-on values
    localparam logic [7:0] CFG1_POR_LOW = 8'h09;
    localparam logic [7:0] CFG1_POR_FULL = 8'h01;
    localparam logic [7:0] CFG1_POR_AUTO = 8'h91;
    localparam logic [7:0] CFG2_POR = 8'h7F;
    localparam logic [6:0] DUTY_POR_LOW = 7'h21;
    localparam logic [6:0] DUTY_POR_FULL = 7'h64;
    localparam logic [6:0] DUTY_POR_AUTO = 7'h00;

    // bus address, arbitrary default
    localparam logic [6:0] SLAVE_ADDR_DEF = 7'h2C;

    // timing
    localparam int CLK_KHZ = 50000;
    localparam int MEAS_PERIOD_MS = 250;
    localparam int MEAS_CYC = MEAS_PERIOD_MS * CLK_KHZ;
    localparam int TIMEOUT_US = 25000;
    localparam int TIMEOUT_CYC = (TIMEOUT_US * CLK_KHZ + 999) / 1000;

    typedef enum logic [3:0] {
        ST_IDLE, ST_ADDR, ST_ACKA, ST_CMD, ST_ACKC, ST_WDAT, ST_ACKW, ST_RDAT, ST_RACK
    } fcc_bus_st_t;

    function automatic logic [7:0] fcc_cfg1_por(input logic [1:0] variant);
        case (variant)
            VAR_LOW_DUTY: fcc_cfg1_por = CFG1_POR_LOW;
            VAR_FULL_DUTY: fcc_cfg1_por = CFG1_POR_FULL;
            default: fcc_cfg1_por = CFG1_POR_AUTO;
        endcase
    endfunction

    function automatic logic [6:0] fcc_duty_por(input logic [1:0] variant);
        case (variant)
            VAR_LOW_DUTY: fcc_duty_por = DUTY_POR_LOW;
            VAR_FULL_DUTY: fcc_duty_por = DUTY_POR_FULL;
            default: fcc_duty_por = DUTY_POR_AUTO;
        endcase
    endfunction

endpackage

// file: hw/fcc_tick.sv
module fcc_tick #(
    parameter int PERIOD = fcc_pkg::MEAS_CYC
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    // control
    input wire logic en,
    // pulse
    output logic tick
);

    localparam int CW = $clog2(PERIOD + 1);
    localparam logic [CW-1:0] LAST = CW'(PERIOD - 1);

    logic [CW-1:0] cnt_r;
    logic [CW-1:0] cnt_nxt;
    logic tick_nxt;

    always_comb begin
        cnt_nxt = cnt_r;
        tick_nxt = 1'b0;
        if (!en) begin
            cnt_nxt = '0;
        end else if (cnt_r == LAST) begin
            cnt_nxt = '0;
            tick_nxt = 1'b1;
        end else begin
            cnt_nxt = cnt_r + CW'(1);
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            cnt_r <= '0;
            tick <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            tick <= tick_nxt;
        end
    end

endmodule

// file: hw/fcc_regs.sv
module fcc_regs #(
    parameter logic [1:0] VARIANT = fcc_pkg::VAR_FULL_DUTY,
    parameter logic [6:0] SLAVE_ADDR = fcc_pkg::SLAVE_ADDR_DEF,
    parameter int MEAS_CYC = fcc_pkg::MEAS_CYC,
    parameter int TIMEOUT_CYC = fcc_pkg::TIMEOUT_CYC
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    // management bus pins
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    // alarm sources and the remote diode fault input
    input wire logic pwm_full_duty,
    input wire logic spinup_active,
    input wire logic thermal_alarm_output_n,
    input wire logic remote_diode_fault,
    // fan control configuration
    output logic auto_mode,
    output logic [1:0] temp_src,
    output logic rpm_mode,
    output logic fan_fail_out_en,
    output logic pwm_active_high,
    output logic tach_analog,
    output logic int_out_en,
    output logic monitor_en,
    output logic fan_ctrl_run,
    output logic meas_tick,
    output logic [6:0] preset_duty,
    // interrupt and output configuration
    output logic remote_int_en,
    output logic local_int_en,
    output logic int_in_mask,
    output logic tach_en,
    output logic bus_timeout_en,
    output logic pwm_out_en,
    // status
    output logic alarm_speed
);

    localparam logic [7:0] CFG1_POR = fcc_pkg::fcc_cfg1_por(VARIANT);
    localparam int TW = $clog2(TIMEOUT_CYC + 1);
    localparam logic [TW-1:0] TO_LAST = TW'(TIMEOUT_CYC - 1);

    // pin synchronisers
    logic scl_q1, scl_s, scl_d;
    logic sda_q1, sda_s, sda_d;

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            scl_q1 <= 1'b1;
            scl_s <= 1'b1;
            scl_d <= 1'b1;
            sda_q1 <= 1'b1;
            sda_s <= 1'b1;
            sda_d <= 1'b1;
        end else begin
            scl_q1 <= scl_i;
            scl_s <= scl_q1;
            scl_d <= scl_s;
            sda_q1 <= sda_i;
            sda_s <= sda_q1;
            sda_d <= sda_s;
        end
    end

    logic scl_rise, scl_fall, bus_start, bus_stop;
    assign scl_rise = scl_s & ~scl_d;
    assign scl_fall = ~scl_s & scl_d;
    assign bus_start = scl_s & scl_d & sda_d & ~sda_s;
    assign bus_stop = scl_s & scl_d & ~sda_d & sda_s;

    // register state
    logic [7:0] cfg1_r, cfg1_nxt;
    logic [7:0] cfg2_r, cfg2_nxt;
    logic run_r, run_nxt;
    logic alarm_r, alarm_nxt;
    logic cond_prev_r, cond_prev_nxt;
    logic por_pend_r, por_pend_nxt;

    // bus state
    fcc_pkg::fcc_bus_st_t st_r, st_nxt;
    logic [3:0] cnt_r, cnt_nxt;
    logic [7:0] sh_r, sh_nxt;
    logic [7:0] tx_r, tx_nxt;
    logic [7:0] ptr_r, ptr_nxt;
    logic rw_r, rw_nxt;
    logic oe_r, oe_nxt;
    logic nack_r, nack_nxt;
    logic [TW-1:0] to_r, to_nxt;
    logic wr_stb, rd_clr;

    function automatic logic [7:0] rd_val(input logic [7:0] addr);
        case (addr)
            fcc_pkg::REG_CFG1: rd_val = cfg1_r;
            fcc_pkg::REG_CFG2: rd_val = {1'b0, cfg2_r[6:0]};
            fcc_pkg::REG_STAT1: rd_val = {7'h00, alarm_r};
            default: rd_val = 8'h00;
        endcase
    endfunction

    always_comb begin
        st_nxt = st_r;
        cnt_nxt = cnt_r;
        sh_nxt = sh_r;
        tx_nxt = tx_r;
        ptr_nxt = ptr_r;
        rw_nxt = rw_r;
        oe_nxt = oe_r;
        nack_nxt = nack_r;
        wr_stb = 1'b0;
        rd_clr = 1'b0;
        if (scl_rise) begin
            case (st_r)
                fcc_pkg::ST_ADDR, fcc_pkg::ST_CMD, fcc_pkg::ST_WDAT: begin
                    sh_nxt = {sh_r[6:0], sda_s};
                    cnt_nxt = cnt_r + 4'h1;
                end
                fcc_pkg::ST_RDAT: cnt_nxt = cnt_r + 4'h1;
                fcc_pkg::ST_RACK: nack_nxt = sda_s;
                default: ;
            endcase
        end
        if (scl_fall) begin
            case (st_r)
                fcc_pkg::ST_ADDR: begin
                    if (cnt_r == 4'h8) begin
                        if (sh_r[7:1] == SLAVE_ADDR) begin
                            st_nxt = fcc_pkg::ST_ACKA;
                            rw_nxt = sh_r[0];
                            oe_nxt = 1'b1;
                        end else begin
                            st_nxt = fcc_pkg::ST_IDLE;
                        end
                    end
                end
                fcc_pkg::ST_ACKA: begin
                    cnt_nxt = 4'h0;
                    if (rw_r) begin
                        st_nxt = fcc_pkg::ST_RDAT;
                        tx_nxt = rd_val(ptr_r);
                        oe_nxt = ~tx_nxt[7];
                    end else begin
                        st_nxt = fcc_pkg::ST_CMD;
                        oe_nxt = 1'b0;
                    end
                end
                fcc_pkg::ST_CMD: begin
                    if (cnt_r == 4'h8) begin
                        ptr_nxt = sh_r;
                        st_nxt = fcc_pkg::ST_ACKC;
                        oe_nxt = 1'b1;
                    end
                end
                fcc_pkg::ST_ACKC, fcc_pkg::ST_ACKW: begin
                    st_nxt = fcc_pkg::ST_WDAT;
                    cnt_nxt = 4'h0;
                    oe_nxt = 1'b0;
                end
                fcc_pkg::ST_WDAT: begin
                    if (cnt_r == 4'h8) begin
                        wr_stb = 1'b1;
                        st_nxt = fcc_pkg::ST_ACKW;
                        oe_nxt = 1'b1;
                    end
                end
                fcc_pkg::ST_RDAT: begin
                    if (cnt_r == 4'h8) begin
                        st_nxt = fcc_pkg::ST_RACK;
                        oe_nxt = 1'b0;
                        rd_clr = (ptr_r == fcc_pkg::REG_STAT1);
                    end else begin
                        tx_nxt = {tx_r[6:0], 1'b0};
                        oe_nxt = ~tx_r[6];
                    end
                end
                fcc_pkg::ST_RACK: begin
                    cnt_nxt = 4'h0;
                    if (nack_r) begin
                        st_nxt = fcc_pkg::ST_IDLE;
                    end else begin
                        st_nxt = fcc_pkg::ST_RDAT;
                        tx_nxt = rd_val(ptr_r);
                        oe_nxt = ~tx_nxt[7];
                    end
                end
                default: ;
            endcase
        end
        // bus timeout on a held-low clock
        if (st_r != fcc_pkg::ST_IDLE && !scl_s && cfg2_r[fcc_pkg::CFG2_TO]) begin
            to_nxt = to_r + TW'(1);
        end else begin
            to_nxt = '0;
        end
        if (to_r == TO_LAST) begin
            st_nxt = fcc_pkg::ST_IDLE;
            oe_nxt = 1'b0;
            to_nxt = '0;
        end
        if (bus_start) begin
            st_nxt = fcc_pkg::ST_ADDR;
            cnt_nxt = 4'h0;
            oe_nxt = 1'b0;
        end
        if (bus_stop) begin
            st_nxt = fcc_pkg::ST_IDLE;
            oe_nxt = 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            st_r <= fcc_pkg::ST_IDLE;
            cnt_r <= 4'h0;
            sh_r <= 8'h00;
            tx_r <= 8'h00;
            ptr_r <= 8'h00;
            rw_r <= 1'b0;
            oe_r <= 1'b0;
            nack_r <= 1'b0;
            to_r <= '0;
        end else begin
            st_r <= st_nxt;
            cnt_r <= cnt_nxt;
            sh_r <= sh_nxt;
            tx_r <= tx_nxt;
            ptr_r <= ptr_nxt;
            rw_r <= rw_nxt;
            oe_r <= oe_nxt;
            nack_r <= nack_nxt;
            to_r <= to_nxt;
        end
    end

    // alarm-speed condition per variant
    logic cond;
    logic cond_rise;
    assign cond = (VARIANT == fcc_pkg::VAR_FULL_DUTY) ?
        (pwm_full_duty & ~spinup_active) : ~thermal_alarm_output_n;
    assign cond_rise = cond & ~cond_prev_r;

    logic wr_mon;
    logic wr_srst;
    assign wr_mon = wr_stb && ptr_r == fcc_pkg::REG_CFG1 && sh_r[fcc_pkg::CFG1_MON];
    assign wr_srst = wr_stb && ptr_r == fcc_pkg::REG_CFG2 && sh_r[fcc_pkg::CFG2_SRST];

    always_comb begin
        cfg1_nxt = cfg1_r;
        cfg2_nxt = cfg2_r;
        run_nxt = run_r;
        alarm_nxt = alarm_r;
        cond_prev_nxt = cond;
        por_pend_nxt = 1'b0;
        if (por_pend_r) begin
            cfg2_nxt[fcc_pkg::CFG2_REM] = ~remote_diode_fault;
        end
        if (wr_stb) begin
            case (ptr_r)
                fcc_pkg::REG_CFG1: begin
                    cfg1_nxt = sh_r;
                    if (wr_mon) begin
                        run_nxt = 1'b1;
                    end
                end
                fcc_pkg::REG_CFG2: begin
                    if (wr_srst) begin
                        cfg1_nxt = CFG1_POR;
                        cfg2_nxt = fcc_pkg::CFG2_POR;
                        run_nxt = 1'b0;
                        alarm_nxt = 1'b0;
                        por_pend_nxt = 1'b1;
                    end else begin
                        cfg2_nxt = {1'b0, sh_r[6:0]};
                    end
                end
                default: ;
            endcase
        end
        if (rd_clr) begin
            alarm_nxt = 1'b0;
        end
        if (cond_rise) begin
            alarm_nxt = 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            cfg1_r <= CFG1_POR;
            cfg2_r <= fcc_pkg::CFG2_POR;
            run_r <= 1'b0;
            alarm_r <= 1'b0;
            cond_prev_r <= 1'b0;
            por_pend_r <= 1'b1;
        end else begin
            cfg1_r <= cfg1_nxt;
            cfg2_r <= cfg2_nxt;
            run_r <= run_nxt;
            alarm_r <= alarm_nxt;
            cond_prev_r <= cond_prev_nxt;
            por_pend_r <= por_pend_nxt;
        end
    end

    // measurement rate divider
    fcc_tick #(
        .PERIOD(MEAS_CYC)
    ) u_meas_tick (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .en(cfg1_r[fcc_pkg::CFG1_MON]),
        .tick(meas_tick)
    );

    // outputs
    assign sda_o = 1'b0;
    assign sda_oe = oe_r;
    assign auto_mode = cfg1_r[fcc_pkg::CFG1_AUTO];
    assign temp_src = cfg1_r[fcc_pkg::CFG1_SRC_HI:fcc_pkg::CFG1_SRC_LO];
    assign rpm_mode = ~cfg1_r[fcc_pkg::CFG1_AUTO] & cfg1_r[fcc_pkg::CFG1_SRC_LO];
    assign fan_fail_out_en = cfg1_r[fcc_pkg::CFG1_FFEN];
    assign pwm_active_high = cfg1_r[fcc_pkg::CFG1_INV];
    assign tach_analog = cfg1_r[fcc_pkg::CFG1_ANA];
    assign int_out_en = cfg1_r[fcc_pkg::CFG1_INTEN];
    assign monitor_en = cfg1_r[fcc_pkg::CFG1_MON];
    assign fan_ctrl_run = run_r & cfg1_r[fcc_pkg::CFG1_MON];
    assign preset_duty = fcc_pkg::fcc_duty_por(VARIANT);
    assign remote_int_en = cfg2_r[fcc_pkg::CFG2_REM];
    assign local_int_en = cfg2_r[fcc_pkg::CFG2_LOC];
    assign int_in_mask = cfg2_r[fcc_pkg::CFG2_INMASK];
    assign tach_en = cfg2_r[fcc_pkg::CFG2_TACH];
    assign bus_timeout_en = cfg2_r[fcc_pkg::CFG2_TO];
    assign pwm_out_en = cfg2_r[fcc_pkg::CFG2_PWM];
    assign alarm_speed = alarm_r;

    // checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);

    sequence s_addr_match;
        scl_fall && st_r == fcc_pkg::ST_ADDR && cnt_r == 4'h8 && sh_r[7:1] == SLAVE_ADDR;
    endsequence

    sequence s_stat_read_done;
        scl_fall && st_r == fcc_pkg::ST_RDAT && cnt_r == 4'h8 && ptr_r == fcc_pkg::REG_STAT1;
    endsequence

    AST_FLAG_SET: assert property (cond && !cond_prev_r |=> alarm_r)
        else $error("alarm flag missed a new condition");
    AST_FLAG_HOLD: assert property (alarm_r && !rd_clr && !wr_srst |=> alarm_r)
        else $error("alarm flag cleared without a status read");
    AST_NO_REARM: assert property (!alarm_r && cond_prev_r && cond |=> !alarm_r)
        else $error("alarm flag set again by a lasting condition");
    AST_READ_CLR: assert property (s_stat_read_done and !(cond && !cond_prev_r)
        |=> !alarm_r)
        else $error("alarm flag not cleared after status read");
    AST_RUN_START: assert property ($rose(run_r) |-> $past(wr_mon))
        else $error("fan control started without monitoring write");
    AST_SOFT_RST: assert property (wr_srst |=> cfg1_r == CFG1_POR && !run_r
        ##1 cfg2_r[7] == 1'b0)
        else $error("soft reset did not restore defaults");
    AST_POLARITY: assert property (wr_stb && ptr_r == fcc_pkg::REG_CFG1
        |=> pwm_active_high == $past(sh_r[fcc_pkg::CFG1_INV]))
        else $error("polarity not taken from write");
    AST_SLEEP: assert property (!monitor_en ##1 !monitor_en |-> !meas_tick)
        else $error("measurement tick while asleep");
    AST_TIMEOUT: assert property (to_r == TO_LAST && !bus_start
        |=> st_r == fcc_pkg::ST_IDLE && !sda_oe)
        else $error("bus not released after timeout");
    AST_ADDR_ACK: assert property (s_addr_match |=> sda_oe ##0 st_r == fcc_pkg::ST_ACKA)
        else $error("address not acknowledged");

endmodule

// file: dv/fcc_host_model.sv
module fcc_host_model (
    // bus pins
    output logic scl,
    output wire logic sda,
    // device pull-downs
    input wire logic oe_a,
    input wire logic oe_b
);
    timeunit 1ns;
    timeprecision 1ns;
    logic hi = 1'b1;
    initial scl = 1'b1;
    // open drain with pull-up
    assign sda = hi && !oe_a && !oe_b;
    // one 160 ns bit, data set late in low phase, sampled late in high phase
    task automatic bit_x(input logic b, output logic s);
        #70 hi = b;
        #10 scl = 1'b1;
        #80 s = sda;
        scl = 1'b0;
    endtask
    // start or repeated start
    task automatic go();
        #70 hi = 1'b1;
        #10 scl = 1'b1;
        #40 hi = 1'b0;
        #40 scl = 1'b0;
    endtask
    // stop, clock then rests high
    task automatic halt();
        #70 hi = 1'b0;
        #10 scl = 1'b1;
        #40 hi = 1'b1;
        #40;
    endtask
    // 8 bits msb first, then ack slot released
    task automatic xbyte(input logic [7:0] b, output logic [7:0] g, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_x(b[i], s);
            g[i] = s;
        end
        bit_x(1'b1, s);
        ack = !s;
    endtask
    task automatic wr(input logic [6:0] dv, input logic [7:0] r, input logic [7:0] d,
        output logic ok);
        logic [7:0] g;
        logic a0, a1, a2;
        go();
        xbyte({dv, 1'b0}, g, a0);
        xbyte(r, g, a1);
        xbyte(d, g, a2);
        halt();
        ok = a0 && a1 && a2;
    endtask
    // pointer write, repeated start, one byte then nack
    task automatic rd(input logic [6:0] dv, input logic [7:0] r, output logic [7:0] d,
        output logic ok);
        logic [7:0] g;
        logic a0, a1, a2, n;
        go();
        xbyte({dv, 1'b0}, g, a0);
        xbyte(r, g, a1);
        go();
        xbyte({dv, 1'b1}, g, a2);
        xbyte(8'hFF, d, n);
        halt();
        ok = a0 && a1 && a2;
    endtask
endmodule

// file: dv/test_fan_controller_config_and_alarm_flag.sv
module test_fan_controller_config_and_alarm_flag;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [6:0] adr_a = 7'h2C;
    localparam logic [6:0] adr_b = 7'h2D;
    localparam int meas = 20;
    logic clk_sys;
    logic nrst = 1'b0;
    logic pwm_full_duty = 1'b0;
    logic spinup_active = 1'b0;
    logic thermal_alarm_output_n = 1'b1;
    logic remote_diode_fault = 1'b0;
    wire scl, sda;
    logic sda_oe_a, sda_oe_b, alarm_a, alarm_b, auto_b;
    logic auto_mode, rpm_mode, fan_fail_out_en, pwm_active_high, tach_analog;
    logic int_out_en, monitor_en, fan_ctrl_run, meas_tick;
    logic remote_int_en, local_int_en, int_in_mask, tach_en, bus_timeout_en, pwm_out_en;
    logic [1:0] temp_src;
    logic [6:0] preset_duty;
    int err_total = 0;
    int total_checks = 0;
    wire [7:0] c1_v = {auto_mode, temp_src, fan_fail_out_en, pwm_active_high, tach_analog,
        int_out_en, monitor_en};
    wire [7:0] c2_v = {2'b00, remote_int_en, local_int_en, int_in_mask, tach_en,
        bus_timeout_en, pwm_out_en};

    fcc_regs #(.MEAS_CYC(meas), .TIMEOUT_CYC(200)) fcc_regs_i (
        .clk_sys(clk_sys), .nrst(nrst), .scl_i(scl), .sda_i(sda), .sda_o(),
        .sda_oe(sda_oe_a), .pwm_full_duty(pwm_full_duty), .spinup_active(spinup_active),
        .thermal_alarm_output_n(thermal_alarm_output_n),
        .remote_diode_fault(remote_diode_fault), .auto_mode(auto_mode), .temp_src(temp_src),
        .rpm_mode(rpm_mode), .fan_fail_out_en(fan_fail_out_en),
        .pwm_active_high(pwm_active_high), .tach_analog(tach_analog),
        .int_out_en(int_out_en), .monitor_en(monitor_en), .fan_ctrl_run(fan_ctrl_run),
        .meas_tick(meas_tick), .preset_duty(preset_duty), .remote_int_en(remote_int_en),
        .local_int_en(local_int_en), .int_in_mask(int_in_mask), .tach_en(tach_en),
        .bus_timeout_en(bus_timeout_en), .pwm_out_en(pwm_out_en), .alarm_speed(alarm_a));
    // second variant shares the bus at another address
    fcc_regs #(.VARIANT(2'h2), .SLAVE_ADDR(adr_b), .MEAS_CYC(meas), .TIMEOUT_CYC(200))
    fcc_regs_b_i (
        .clk_sys(clk_sys), .nrst(nrst), .scl_i(scl), .sda_i(sda), .sda_o(),
        .sda_oe(sda_oe_b), .pwm_full_duty(pwm_full_duty), .spinup_active(spinup_active),
        .thermal_alarm_output_n(thermal_alarm_output_n),
        .remote_diode_fault(remote_diode_fault), .auto_mode(auto_b), .temp_src(),
        .rpm_mode(), .fan_fail_out_en(), .pwm_active_high(), .tach_analog(),
        .int_out_en(), .monitor_en(), .fan_ctrl_run(), .meas_tick(), .preset_duty(),
        .remote_int_en(), .local_int_en(), .int_in_mask(), .tach_en(),
        .bus_timeout_en(), .pwm_out_en(), .alarm_speed(alarm_b));
    fcc_host_model fcc_host_model_i (.scl(scl), .sda(sda), .oe_a(sda_oe_a), .oe_b(sda_oe_b));

    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        total_checks++;
        if (g !== e) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic flag(input string nm, input logic e, input logic g);
        chk(nm, {7'h00, e}, {7'h00, g});
    endtask
    task automatic wr(input logic [6:0] dv, input logic [7:0] r, input logic [7:0] d);
        logic ok;
        @(negedge clk_sys);
        #3;
        fcc_host_model_i.wr(dv, r, d, ok);
        flag("write ack", 1'b1, ok);
    endtask
    task automatic rdc(input string nm, input logic [6:0] dv, input logic [7:0] r,
        input logic [7:0] e);
        logic ok;
        logic [7:0] d;
        @(negedge clk_sys);
        #3;
        fcc_host_model_i.rd(dv, r, d, ok);
        flag("read ack", 1'b1, ok);
        chk(nm, e, d);
    endtask

    task automatic t_por();
        int n;
        chk("cfg1 pins", 8'h01, c1_v);
        chk("cfg2 pins", 8'h3F, c2_v);
        flag("run", 1'b0, fan_ctrl_run);
        chk("duty", 8'h64, {1'b0, preset_duty});
        flag("auto b", 1'b1, auto_b);
        rdc("cfg1", adr_a, 8'h00, 8'h01);
        rdc("cfg2", adr_a, 8'h01, 8'h7F);
        rdc("status", adr_a, 8'h02, 8'h00);
        rdc("cfg1 b", adr_b, 8'h00, 8'h91);
        for (int k = 0; k < 2; k++) begin
            n = 0;
            do begin
                @(negedge clk_sys);
                n++;
            end while (meas_tick !== 1'b1 && n < 100);
        end
        chk("tick gap", 8'(meas), n[7:0]);
        $display("t_por done");
    endtask

    task automatic t_cfg();
        logic [7:0] v [6] = '{8'hE0, 8'h81, 8'h21, 8'h1E, 8'h01, 8'h00};
        wr(adr_a, 8'h01, 8'h55);
        chk("cfg2 pins", 8'h15, c2_v);
        rdc("cfg2", adr_a, 8'h01, 8'h55);
        wr(adr_a, 8'h01, 8'h2A);
        chk("cfg2 pins", 8'h2A, c2_v);
        foreach (v[i]) begin
            wr(adr_a, 8'h00, v[i]);
            chk("cfg1 pins", v[i], c1_v);
            flag("rpm", !v[i][7] && v[i][5], rpm_mode);
            flag("run", v[i][0], fan_ctrl_run);
            rdc("cfg1", adr_a, 8'h00, v[i]);
        end
        $display("t_cfg done");
    endtask

    task automatic t_srst();
        wr(adr_a, 8'h00, 8'h3F);
        @(negedge clk_sys);
        remote_diode_fault = 1'b1;
        wr(adr_a, 8'h01, 8'h80);
        chk("cfg1 pins", 8'h01, c1_v);
        flag("run", 1'b0, fan_ctrl_run);
        rdc("cfg2", adr_a, 8'h01, 8'h5F);
        @(negedge clk_sys);
        remote_diode_fault = 1'b0;
        wr(adr_a, 8'h01, 8'h80);
        rdc("cfg2", adr_a, 8'h01, 8'h7F);
        $display("t_srst done");
    endtask

    task automatic t_alarm();
        @(negedge clk_sys);
        pwm_full_duty = 1'b1;
        spinup_active = 1'b1;
        repeat (5) @(negedge clk_sys);
        flag("alarm in spinup", 1'b0, alarm_a);
        spinup_active = 1'b0;
        repeat (3) @(negedge clk_sys);
        flag("alarm at full", 1'b1, alarm_a);
        wr(adr_a, 8'h02, 8'h00);
        flag("alarm after write", 1'b1, alarm_a);
        rdc("status", adr_a, 8'h02, 8'h01);
        flag("alarm after read", 1'b0, alarm_a);
        repeat (50) @(negedge clk_sys);
        flag("alarm persisting", 1'b0, alarm_a);
        pwm_full_duty = 1'b0;
        repeat (3) @(negedge clk_sys);
        pwm_full_duty = 1'b1;
        repeat (3) @(negedge clk_sys);
        flag("alarm on return", 1'b1, alarm_a);
        rdc("status", adr_a, 8'h02, 8'h01);
        @(negedge clk_sys);
        pwm_full_duty = 1'b0;
        thermal_alarm_output_n = 1'b0;
        repeat (3) @(negedge clk_sys);
        flag("thermal alarm", 1'b1, alarm_b);
        rdc("status b", adr_b, 8'h02, 8'h01);
        flag("thermal cleared", 1'b0, alarm_b);
        @(negedge clk_sys);
        thermal_alarm_output_n = 1'b1;
        $display("t_alarm done");
    endtask

    task automatic t_tmo();
        logic [7:0] g;
        logic a;
        for (int k = 0; k < 2; k++) begin
            wr(adr_a, 8'h01, k ? 8'h7D : 8'h7F);
            fcc_host_model_i.go();
            fcc_host_model_i.xbyte({adr_a, 1'b0}, g, a);
            fcc_host_model_i.xbyte(8'h01, g, a);
            fcc_host_model_i.go();
            fcc_host_model_i.xbyte({adr_a, 1'b1}, g, a);
            #400;
            flag("oe first bit", 1'b1, sda_oe_a);
            #6000;
            flag("oe after stall", k[0], sda_oe_a);
            fcc_host_model_i.xbyte(8'hFF, g, a);
            fcc_host_model_i.halt();
        end
        chk("read after stall", 8'h7D, g);
        $display("t_tmo done");
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end
    initial begin
        repeat (20) @(negedge clk_sys);
        nrst = 1'b1;
        repeat (4) @(negedge clk_sys);
        t_por();
        t_cfg();
        t_srst();
        t_alarm();
        t_tmo();
        complete_run();
    end
    // about five times the expected run of some 32 transfers
    initial begin
        #1000000;
        err_total++;
        complete_run();
    end
endmodule
